/* File: hw/fsic_cfg.svh */
`ifndef FSIC_CFG_SVH
`define FSIC_CFG_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define FSIC_ADDR_CMD 8'h00
`define FSIC_ADDR_SPEC 8'h04
`define FSIC_ADDR_CTRL 8'h08
`define FSIC_ADDR_STAT 8'h0c
`define FSIC_ADDR_RSLT 8'h10

// ----------------------------------------------------------------
// Command word fields and opcodes
// ----------------------------------------------------------------
`define FSIC_CMD_OP_LSB 0
`define FSIC_CMD_OP_MSB 2
`define FSIC_CMD_NCN_LSB 8
`define FSIC_CMD_NCN_MSB 15
`define FSIC_OP_RECAL 3'h1
`define FSIC_OP_SEEK 3'h2
`define FSIC_OP_SENSE_INT 3'h3
`define FSIC_OP_SENSE_DRV 3'h4

// ----------------------------------------------------------------
// Specify word fields and reset values
// ----------------------------------------------------------------
`define FSIC_SPEC_SRT_LSB 0
`define FSIC_SPEC_SRT_MSB 3
`define FSIC_SPEC_HUT_LSB 4
`define FSIC_SPEC_HUT_MSB 7
`define FSIC_SPEC_HLT_LSB 8
`define FSIC_SPEC_HLT_MSB 14
`define FSIC_SPEC_RATE_LSB 16
`define FSIC_SPEC_RATE_MSB 18
`define FSIC_SPEC_ND_BIT 19
`define FSIC_SRT_RST 4'h0
`define FSIC_HUT_RST 4'h0
`define FSIC_HLT_RST 7'h00
`define FSIC_RATE_RST 3'h2
`define FSIC_CTRL_LP_BIT 0

// ----------------------------------------------------------------
// Status word bits
// ----------------------------------------------------------------
`define FSIC_STAT_CMD_BUSY 0
`define FSIC_STAT_POS_BUSY 1
`define FSIC_STAT_RQM 2
`define FSIC_STAT_RES_VALID 3
`define FSIC_STAT_IRQ 4
`define FSIC_STAT_LOW_POWER 5

// ----------------------------------------------------------------
// Status register zero layout and cause codes
// ----------------------------------------------------------------
`define FSIC_IC_NORMAL 2'h0
`define FSIC_IC_ABNORMAL 2'h1
`define FSIC_IC_INVALID 2'h2
`define FSIC_IC_POLL 2'h3
`define FSIC_RECAL_MAX_STEPS 7'h4f

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FSIC_CLK_PERIOD_NS 20
`define FSIC_QUANT_NS 250000
`define FSIC_QUANT_CYC ((`FSIC_QUANT_NS + `FSIC_CLK_PERIOD_NS - 1) / `FSIC_CLK_PERIOD_NS)
`define FSIC_STEP_PULSE_NS 1000
`define FSIC_STEP_CYC ((`FSIC_STEP_PULSE_NS + `FSIC_CLK_PERIOD_NS - 1) / `FSIC_CLK_PERIOD_NS)
`define FSIC_HUT_SCALE 16
`define FSIC_HLT_SCALE 2
`define FSIC_UNITS_MAX 9'h100

`endif

/* File: hw/fsic_pkg.sv */
package fsic_pkg;

	typedef enum logic [1:0] {
		FSIC_POS_IDLE = 2'b00,
		FSIC_POS_CHECK = 2'b01,
		FSIC_POS_PULSE = 2'b10,
		FSIC_POS_SPACE = 2'b11
	} fsic_pos_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		fsic_pos_t pos;
		logic recal;
		logic [7:0] present_cylinder;
		logic [7:0] target_cylinder;
		logic [6:0] pulses;
		logic [5:0] wid;
		logic dir;
		logic step;
		logic pos_busy;
		logic cmd_busy;
		logic [3:0] step_rate_time;
		logic [3:0] head_unload_time;
		logic [6:0] head_load_time;
		logic no_dma_select;
		logic [2:0] rate;
		logic low_power_state;
		logic end_pend;
		logic end_ec;
		logic poll_pend;
		logic irq_evt;
		logic [7:0] status_register_zero;
		logic [7:0] status_register_three;
		logic [7:0] res_cylinder;
		logic res_valid;
		logic head_load;
		logic hl_wait;
		logic head_ready;
		logic controller_irq;
		logic controller_dma_request;
	} fsic_regs_t;

	typedef struct packed {
		logic [31:0] pre;
		logic [8:0] units;
		logic running;
		logic expired;
	} fsic_dly_t;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
	} fsic_sync_t;

endpackage

/* File: hw/fsic_dly_if.sv */
`timescale 1ns/1ns
interface fsic_dly_if;
	logic load;
	logic [31:0] period;
	logic [8:0] units;
	logic running;
	logic expired;
	modport ctl(output load, output period, output units, input running, input expired);
	modport tmr(input load, input period, input units, output running, output expired);
endinterface

/* File: hw/fsic_sync.sv */
`timescale 1ns/1ns
module fsic_sync
	import fsic_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic [1:0] d_i,
	output logic [1:0] q_o
);
	fsic_sync_t r;
	fsic_sync_t n;

	always_comb begin
		n = r;
		n.s1 = d_i;
		n.s2 = r.s1;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= '0;
		end else if (ce_i) begin
			r <= n;
		end
	end

	assign q_o = r.s2;
endmodule // fsic_sync

/* File: hw/fsic_delay.sv */
`timescale 1ns/1ns
module fsic_delay
	import fsic_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	fsic_dly_if.tmr dly
);
	// Counts units times period cycles; a new load restarts the count.
	fsic_dly_t r;
	fsic_dly_t n;

	always_comb begin
		n = r;
		n.expired = 1'b0;
		if (dly.load) begin
			n.pre = dly.period - 32'h0000_0001;
			n.units = dly.units;
			n.running = 1'b1;
		end else if (r.running) begin
			if (r.pre == 32'h0000_0000) begin
				n.pre = dly.period - 32'h0000_0001;
				if (r.units <= 9'h001) begin
					n.running = 1'b0;
					n.expired = 1'b1;
				end else begin
					n.units = r.units - 9'h001;
				end
			end else begin
				n.pre = r.pre - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= '0;
		end else if (ce_i) begin
			r <= n;
		end
	end

	// Running drops in the last counted cycle, so a waiting sequencer acts on
	// the very edge at which the count ends and adds no cycles of its own.
	assign dly.running = r.running & ~((r.pre == 32'h0000_0000) & (r.units <= 9'h001));
	assign dly.expired = r.expired;
endmodule // fsic_delay

/* File: hw/fsic_top.sv */
// Operation
// - Head return zeroes cylinder, drives direction 0, steps while track-zero is low.
// - Head return ends with seek-end set when track-zero goes high.
// - After 79 pulses without track-zero, set seek-end and equipment-check, end.
// - Busy only in command phase; positioning runs non-busy.
// - Seek with cylinder below target steps inward, direction 1.
// - Seek with cylinder above target steps outward, direction 0.
// - Pulses spaced by step rate; compare after each, equality ends with seek-end.
// - Head-address bit of status zero always reads 0 after positioning.
// - Leaving low power clears cylinder and stored status.
// - Result phase of data commands raises the interrupt.
// - End of seek or head return raises the interrupt.
// - Non-DMA byte requests raise the interrupt.
// - Interrupt query clears interrupt and reports cause in status zero.
// - Drive query skips execution and returns status register three.
// - Head unload time runs from end of data execution to unload.
// - Step rate code sets pulse spacing, scaled by data rate.
// - Head load time delays start after head load, scaled by rate.
// - Transfer mode bit 1 selects non-DMA, 0 selects DMA.
// - DMA mode uses DMA request; non-DMA uses master request and interrupt.
`timescale 1ns/1ns
`include "fsic_cfg.svh"
module fsic_top
	import fsic_pkg::*;
#(
	parameter int unsigned QUANT_CYCLES = `FSIC_QUANT_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic track_zero_n_i,
	input wire logic write_protect_i,
	input wire logic rw_result_i,
	input wire logic rw_start_i,
	input wire logic rw_exec_done_i,
	input wire logic xfer_req_i,
	output logic step_o,
	output logic dir_o,
	output logic head_load_o,
	output logic head_ready_o,
	output logic controller_irq_o,
	output logic controller_dma_request_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Cycles per timing quantum at the selected rate, kept in thirds so
	// that the 300K rate scales without a fractional divider.
	function automatic logic [31:0] rate_period(input logic [2:0] rate);
		logic [31:0] thirds;
		thirds = 32'h0000_0003;
		case (rate)
			3'h0: thirds = 32'h0000_0003;
			3'h1: thirds = 32'h0000_0006;
			3'h2: thirds = 32'h0000_000c;
			3'h3: thirds = 32'h0000_0014;
			3'h4: thirds = 32'h0000_0018;
			default: thirds = 32'h0000_000c;
		endcase
		return 32'(QUANT_CYCLES) * thirds / 32'h0000_0003;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a == `FSIC_ADDR_CMD) || (a == `FSIC_ADDR_SPEC) || (a == `FSIC_ADDR_CTRL) ||
			(a == `FSIC_ADDR_STAT) || (a == `FSIC_ADDR_RSLT);
	endfunction

	function automatic logic [7:0] make_st0(input logic [1:0] ic, input logic se,
		input logic ec);
		// Head address and drive select stay zero: one drive, head bit fixed.
		return {ic, se, ec, 1'b0, 1'b0, 2'b00};
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	fsic_regs_t r;
	fsic_regs_t n;
	logic [1:0] pins;
	logic tr0;
	logic wp;
	logic access;
	logic wr;
	logic [2:0] op;
	logic [7:0] next_cyl;
	logic finish;
	logic fin_ec;
	logic irq_set;
	logic irq_clr;
	logic step_load;
	logic head_ld;
	logic [8:0] head_units;
	fsic_pos_t pos_now;

	fsic_dly_if step_dly ();
	fsic_dly_if head_dly ();

	fsic_sync u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.d_i({write_protect_i, track_zero_n_i}),
		.q_o(pins)
	);

	fsic_delay u_step_dly (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.dly(step_dly.tmr)
	);

	fsic_delay u_head_dly (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.dly(head_dly.tmr)
	);

	assign tr0 = pins[0];
	assign wp = pins[1];
	assign access = psel_i & penable_i;
	assign wr = access & r.pready & pwrite_i;
	assign op = pwdata_i[`FSIC_CMD_OP_MSB:`FSIC_CMD_OP_LSB];

	assign step_dly.load = step_load;
	assign step_dly.period = rate_period(r.rate);
	assign step_dly.units = {5'h00, 4'hf - r.step_rate_time} + 9'h001;
	assign head_dly.load = head_ld;
	assign head_dly.period = rate_period(r.rate);
	assign head_dly.units = head_units;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		n.cmd_busy = 1'b0;
		n.head_ready = 1'b0;
		finish = 1'b0;
		fin_ec = 1'b0;
		irq_clr = 1'b0;
		step_load = 1'b0;
		head_ld = 1'b0;
		head_units = 9'h000;
		next_cyl = r.dir ? r.present_cylinder + 8'h01 : r.present_cylinder - 8'h01;

		// APB: one wait state, answer registered.
		n.pready = access & ~r.pready;
		n.pslverr = access & ~r.pready & ~mapped(paddr_i);
		if (access & ~r.pready) begin
			n.prdata = 32'h0000_0000;
			case (paddr_i)
				`FSIC_ADDR_SPEC: begin
					n.prdata[`FSIC_SPEC_SRT_MSB:`FSIC_SPEC_SRT_LSB] = r.step_rate_time;
					n.prdata[`FSIC_SPEC_HUT_MSB:`FSIC_SPEC_HUT_LSB] = r.head_unload_time;
					n.prdata[`FSIC_SPEC_HLT_MSB:`FSIC_SPEC_HLT_LSB] = r.head_load_time;
					n.prdata[`FSIC_SPEC_RATE_MSB:`FSIC_SPEC_RATE_LSB] = r.rate;
					n.prdata[`FSIC_SPEC_ND_BIT] = r.no_dma_select;
				end
				`FSIC_ADDR_CTRL: n.prdata[`FSIC_CTRL_LP_BIT] = r.low_power_state;
				`FSIC_ADDR_STAT: begin
					n.prdata[`FSIC_STAT_CMD_BUSY] = r.cmd_busy;
					n.prdata[`FSIC_STAT_POS_BUSY] = r.pos_busy;
					n.prdata[`FSIC_STAT_RQM] = ~r.cmd_busy & (~xfer_req_i | r.no_dma_select);
					n.prdata[`FSIC_STAT_RES_VALID] = r.res_valid;
					n.prdata[`FSIC_STAT_IRQ] = r.controller_irq;
					n.prdata[`FSIC_STAT_LOW_POWER] = r.low_power_state;
				end
				`FSIC_ADDR_RSLT: n.prdata[23:0] = {r.status_register_three, r.res_cylinder,
					r.status_register_zero};
				default: n.prdata = 32'h0000_0000;
			endcase
		end

		// Positioning sequencer. The spacing wait turns into a check in the
		// timer's last cycle, so each pulse starts one step time after the last.
		pos_now = r.pos;
		if (r.pos == FSIC_POS_SPACE && !step_dly.running) begin
			pos_now = FSIC_POS_CHECK;
		end
		unique case (pos_now)
			FSIC_POS_IDLE: begin
			end
			FSIC_POS_CHECK: begin
				if (r.recal) begin
					if (tr0) begin
						finish = 1'b1;
					end else if (r.pulses == `FSIC_RECAL_MAX_STEPS) begin
						finish = 1'b1;
						fin_ec = 1'b1;
					end else begin
						n.dir = 1'b0;
						n.step = 1'b1;
					end
				end else if (r.present_cylinder == r.target_cylinder) begin
					finish = 1'b1;
				end else begin
					n.dir = r.present_cylinder < r.target_cylinder;
					n.step = 1'b1;
				end
				if (n.step) begin
					n.wid = 6'(`FSIC_STEP_CYC - 1);
					step_load = 1'b1;
					n.pos = FSIC_POS_PULSE;
				end
			end
			FSIC_POS_PULSE: begin
				if (r.wid == 6'h00) begin
					n.step = 1'b0;
					if (r.recal) begin
						n.pulses = r.pulses + 7'h01;
						n.pos = FSIC_POS_SPACE;
					end else begin
						n.present_cylinder = next_cyl;
						if (next_cyl == r.target_cylinder) begin
							finish = 1'b1;
						end else begin
							n.pos = FSIC_POS_SPACE;
						end
					end
				end else begin
					n.wid = r.wid - 6'h01;
				end
			end
			FSIC_POS_SPACE: begin
				// Still spacing: the timer started with the pulse.
			end
		endcase
		if (finish) begin
			n.pos = FSIC_POS_IDLE;
			n.end_pend = 1'b1;
			n.end_ec = fin_ec;
		end

		// Register writes; commands are refused in low power.
		if (wr && paddr_i == `FSIC_ADDR_SPEC) begin
			n.step_rate_time = pwdata_i[`FSIC_SPEC_SRT_MSB:`FSIC_SPEC_SRT_LSB];
			n.head_unload_time = pwdata_i[`FSIC_SPEC_HUT_MSB:`FSIC_SPEC_HUT_LSB];
			n.head_load_time = pwdata_i[`FSIC_SPEC_HLT_MSB:`FSIC_SPEC_HLT_LSB];
			n.rate = pwdata_i[`FSIC_SPEC_RATE_MSB:`FSIC_SPEC_RATE_LSB];
			n.no_dma_select = pwdata_i[`FSIC_SPEC_ND_BIT];
		end
		if (wr && paddr_i == `FSIC_ADDR_CTRL) begin
			n.low_power_state = pwdata_i[`FSIC_CTRL_LP_BIT];
			if (r.low_power_state && !pwdata_i[`FSIC_CTRL_LP_BIT]) begin
				n.present_cylinder = 8'h00;
				n.status_register_zero = 8'h00;
				n.status_register_three = 8'h00;
				n.res_cylinder = 8'h00;
				n.end_pend = 1'b0;
				n.end_ec = 1'b0;
				n.poll_pend = 1'b0;
				n.res_valid = 1'b0;
			end
		end
		if (wr && paddr_i == `FSIC_ADDR_CMD && !r.low_power_state) begin
			n.cmd_busy = 1'b1;
			case (op)
				`FSIC_OP_RECAL: begin
					if (!r.pos_busy) begin
						n.pos_busy = 1'b1;
						n.recal = 1'b1;
						n.present_cylinder = 8'h00;
						n.pulses = 7'h00;
						n.pos = FSIC_POS_CHECK;
					end
				end
				`FSIC_OP_SEEK: begin
					if (!r.pos_busy) begin
						n.pos_busy = 1'b1;
						n.recal = 1'b0;
						n.target_cylinder = pwdata_i[`FSIC_CMD_NCN_MSB:`FSIC_CMD_NCN_LSB];
						n.pos = FSIC_POS_CHECK;
					end
				end
				`FSIC_OP_SENSE_INT: begin
					irq_clr = 1'b1;
					n.res_valid = 1'b1;
					n.res_cylinder = r.present_cylinder;
					if (r.end_pend) begin
						n.status_register_zero = make_st0(r.end_ec ? `FSIC_IC_ABNORMAL :
							`FSIC_IC_NORMAL, 1'b1, r.end_ec);
						n.end_pend = finish;
						n.pos_busy = finish;
					end else if (r.poll_pend) begin
						n.status_register_zero = make_st0(`FSIC_IC_POLL, 1'b0, 1'b0);
						n.poll_pend = 1'b0;
					end else begin
						n.status_register_zero = make_st0(`FSIC_IC_INVALID, 1'b0, 1'b0);
					end
				end
				`FSIC_OP_SENSE_DRV: begin
					n.status_register_three = {1'b0, wp, 1'b1, tr0, 1'b1, 1'b0, 2'b00};
					n.res_valid = 1'b1;
				end
				default: n.cmd_busy = 1'b1;
			endcase
		end

		// Interrupt: a new cause in the clearing cycle wins over the clear.
		irq_set = finish | rw_result_i;
		n.irq_evt = (r.irq_evt & ~irq_clr) | irq_set;
		n.controller_irq = n.irq_evt | (r.no_dma_select & xfer_req_i);
		n.controller_dma_request = ~r.no_dma_select & xfer_req_i;

		// Head load and unload timing.
		if (head_dly.expired) begin
			if (r.hl_wait) begin
				n.head_ready = 1'b1;
				n.hl_wait = 1'b0;
			end else begin
				n.head_load = 1'b0;
			end
		end
		if (rw_exec_done_i && r.head_load) begin
			head_ld = 1'b1;
			head_units = (r.head_unload_time == 4'h0) ? `FSIC_UNITS_MAX :
				9'(r.head_unload_time) * 9'(`FSIC_HUT_SCALE);
			n.hl_wait = 1'b0;
		end
		if (rw_start_i) begin
			if (r.head_load && !r.hl_wait) begin
				// Already loaded: abandon any pending unload and go at once.
				n.head_ready = 1'b1;
				head_ld = 1'b1;
				head_units = `FSIC_UNITS_MAX;
				n.hl_wait = 1'b1;
				n.head_ready = 1'b1;
			end else begin
				n.head_load = 1'b1;
				n.hl_wait = 1'b1;
				head_ld = 1'b1;
				head_units = (r.head_load_time == 7'h00) ? `FSIC_UNITS_MAX :
					9'(r.head_load_time) * 9'(`FSIC_HLT_SCALE);
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= '0;
			r.pos <= FSIC_POS_IDLE;
			r.step_rate_time <= `FSIC_SRT_RST;
			r.head_unload_time <= `FSIC_HUT_RST;
			r.head_load_time <= `FSIC_HLT_RST;
			r.rate <= `FSIC_RATE_RST;
			// A single polling interrupt follows reset.
			r.poll_pend <= 1'b1;
			r.irq_evt <= 1'b1;
			r.controller_irq <= 1'b1;
		end else if (ce_i) begin
			r <= n;
		end
	end

	assign prdata_o = r.prdata;
	assign pready_o = r.pready;
	assign pslverr_o = r.pslverr;
	assign step_o = r.step;
	assign dir_o = r.dir;
	assign head_load_o = r.head_load;
	assign head_ready_o = r.head_ready;
	assign controller_irq_o = r.controller_irq;
	assign controller_dma_request_o = r.controller_dma_request;

endmodule // fsic_top

/* File: bench/fsic_top_asserts.sv */
`timescale 1ns/1ns
`include "fsic_cfg.svh"
module fsic_top_asserts #(
	parameter int unsigned QUANT_CYCLES = `FSIC_QUANT_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic track_zero_n_i,
	input wire logic rw_result_i,
	input wire logic xfer_req_i,
	input wire logic step_o,
	input wire logic dir_o,
	input wire logic controller_irq_o,
	input wire logic controller_dma_request_o
);
	// ----
	// Command tracking
	// ----
	logic nd_q, recal_q;
	logic [6:0] cnt;
	wire wr_w = psel_i && penable_i && pready_o && pwrite_i;
	wire cmd_w = wr_w && paddr_i == `FSIC_ADDR_CMD;
	wire spec_w = wr_w && paddr_i == `FSIC_ADDR_SPEC;
	wire [2:0] op = pwdata_i[2:0];
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			nd_q <= 1'b0;
			recal_q <= 1'b0;
			cnt <= 7'h00;
		end else begin
			if (spec_w)
				nd_q <= pwdata_i[19];
			if (cmd_w && op == `FSIC_OP_RECAL) begin
				recal_q <= 1'b1;
				cnt <= 7'h00;
			end else if (cmd_w && op == `FSIC_OP_SEEK)
				recal_q <= 1'b0;
			else if ($rose(step_o))
				cnt <= cnt + 7'h01;
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence pulse_s;
		##49 step_o ##1 !step_o;
	endsequence
	// Six quiet cycles cover the two-flop pin synchroniser with margin.
	sequence tz_home_s;
		(recal_q && track_zero_n_i)[*6];
	endsequence
	step_width_a: assert property ($rose(step_o) |-> pulse_s)
		else $error("step pulse width wrong");
	dir_hold_a: assert property (step_o && $past(step_o) |-> $stable(dir_o))
		else $error("direction moved during a pulse");
	recal_dir_a: assert property (recal_q && step_o |-> !dir_o)
		else $error("head return stepped inward");
	recal_stop_a: assert property (tz_home_s |-> !$rose(step_o))
		else $error("step issued at track zero");
	recal_count_a: assert property (recal_q |-> cnt <= `FSIC_RECAL_MAX_STEPS)
		else $error("too many head return pulses");
	query_clear_a: assert property (cmd_w && op == `FSIC_OP_SENSE_INT
		|-> ##[1:2] !controller_irq_o)
		else $error("query left interrupt set");
	result_irq_a: assert property (rw_result_i |-> ##[1:2] controller_irq_o)
		else $error("no interrupt on result phase");
	pio_irq_a: assert property (xfer_req_i && nd_q |-> ##[1:2] controller_irq_o)
		else $error("no interrupt for byte request");
	dma_mode_a: assert property (!spec_w |=>
		controller_dma_request_o == ($past(xfer_req_i) && !nd_q))
		else $error("dma request wrong for mode");
endmodule // fsic_top_asserts

bind fsic_top fsic_top_asserts #(.QUANT_CYCLES(QUANT_CYCLES)) u_asserts (
	.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.track_zero_n_i(track_zero_n_i), .rw_result_i(rw_result_i), .xfer_req_i(xfer_req_i),
	.step_o(step_o), .dir_o(dir_o), .controller_irq_o(controller_irq_o),
	.controller_dma_request_o(controller_dma_request_o)
);

/* File: bench/fsic_drive_model.sv */
`timescale 1ns/1ns
module fsic_drive_model #(
	parameter int START = 5
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic step_i,
	input wire logic dir_i,
	output logic track_zero_n_o,
	output int track_o
);
	// ----
	// Head carriage
	// ----
	logic step_q;
	// The carriage stops at track zero, so surplus outward pulses do nothing.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			step_q <= 1'b0;
			track_o <= START;
		end else begin
			step_q <= step_i;
			if (step_i && !step_q && dir_i)
				track_o <= track_o + 1;
			else if (step_i && !step_q && track_o > 0)
				track_o <= track_o - 1;
		end
	end
	assign track_zero_n_o = (track_o == 0);
endmodule // fsic_drive_model

/* File: bench/floppy_seek_interrupt_control_bench.sv */
`timescale 1ns/1ns
`include "fsic_cfg.svh"
module floppy_seek_interrupt_control_bench;
	// ----
	// Signals and instances
	// ----
	logic clk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, r;
	logic rw_result_i = 1'b0, rw_start_i = 1'b0, rw_done_i = 1'b0, xfer_req_i = 1'b0;
	logic pready_o, pslverr_o, step_o, dir_o, head_load_o, head_ready_o, e;
	logic controller_irq_o, controller_dma_request_o, track_zero_n_i;
	int track, n;
	int n_errors = 0;
	int total_checks = 0;
	always #10 clk_i = ~clk_i;
	fsic_top #(.QUANT_CYCLES(4)) i_dut (
		.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .track_zero_n_i(track_zero_n_i),
		.write_protect_i(1'b1), .rw_result_i(rw_result_i), .rw_start_i(rw_start_i),
		.rw_exec_done_i(rw_done_i), .xfer_req_i(xfer_req_i), .step_o(step_o), .dir_o(dir_o),
		.head_load_o(head_load_o), .head_ready_o(head_ready_o),
		.controller_irq_o(controller_irq_o),
		.controller_dma_request_o(controller_dma_request_o)
	);
	fsic_drive_model #(.START(5)) i_drive (.clk_i(clk_i), .nrst_i(nrst_i), .step_i(step_o),
		.dir_i(dir_o), .track_zero_n_o(track_zero_n_i), .track_o(track));
	// ----
	// Shared tasks
	// ----
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic time_out();
		chk(32'h0000_0000, 32'h0000_0001);
		finish_test();
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready_o !== 1'b1 && k < 50);
		if (k >= 50)
			time_out();
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic cmd(input logic [2:0] op, input logic [7:0] tgt);
		apb(1'b1, `FSIC_ADDR_CMD, {16'h0000, tgt, 5'h00, op});
	endtask
	task automatic query(input logic [31:0] exp);
		cmd(`FSIC_OP_SENSE_INT, 8'h00);
		apb(1'b0, `FSIC_ADDR_RSLT, 32'h0000_0000);
		chk(r & 32'h0000_ffff, exp);
		chk1(controller_irq_o, 1'b0);
	endtask
	task automatic clear_irq();
		cmd(`FSIC_OP_SENSE_INT, 8'h00);
		repeat (2) @(posedge clk_i);
		chk1(controller_irq_o, 1'b0);
	endtask
	task automatic meas(input logic sel, input logic want);
		n = 0;
		while ((sel ? head_load_o : head_ready_o) !== want) begin
			@(posedge clk_i);
			n++;
			if (n > 1000)
				time_out();
		end
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_basic();
		chk1(controller_irq_o, 1'b1);
		query(32'h0000_00c0);
		apb(1'b1, `FSIC_ADDR_SPEC, 32'h0000_0210);
		apb(1'b0, `FSIC_ADDR_SPEC, 32'h0000_0000);
		chk(r, 32'h0000_0210);
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk1(e, 1'b1);
		chk(r, 32'h0000_0000);
	endtask
	// Spacing is taken fall to fall: pulses have a fixed width and the first rise
	// comes before this loop starts.
	task automatic pos(input logic [2:0] op, input logic [7:0] tgt, input logic [31:0] res,
		input int trk, input int gap);
		int t0, g, k;
		logic p;
		t0 = 0;
		g = 0;
		k = 0;
		p = 1'b0;
		cmd(op, tgt);
		apb(1'b0, `FSIC_ADDR_STAT, 32'h0000_0000);
		chk(r & 32'h0000_0003, 32'h0000_0002);
		while (controller_irq_o !== 1'b1) begin
			@(posedge clk_i);
			k++;
			if (k > 20000)
				time_out();
			if (step_o === 1'b0 && p === 1'b1 && t0 > 0 && g == 0)
				g = k - t0;
			if (step_o === 1'b0 && p === 1'b1 && t0 == 0)
				t0 = k;
			p = step_o;
		end
		chk(track, trk);
		if (gap > 0)
			chk(g, gap);
		query(res);
		apb(1'b0, `FSIC_ADDR_STAT, 32'h0000_0000);
		chk(r & 32'h0000_0002, 32'h0000_0000);
	endtask
	task automatic t_xfer();
		xfer_req_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk1(controller_dma_request_o, 1'b1);
		chk1(controller_irq_o, 1'b0);
		apb(1'b1, `FSIC_ADDR_SPEC, 32'h0008_0210);
		apb(1'b0, `FSIC_ADDR_STAT, 32'h0000_0000);
		chk(r & 32'h0000_0014, 32'h0000_0014);
		chk1(controller_dma_request_o, 1'b0);
		xfer_req_i <= 1'b0;
		clear_irq();
		apb(1'b1, `FSIC_ADDR_SPEC, 32'h0000_0210);
	endtask
	task automatic t_head();
		rw_result_i <= 1'b1;
		@(posedge clk_i);
		rw_result_i <= 1'b0;
		rw_start_i <= 1'b1;
		@(posedge clk_i);
		rw_start_i <= 1'b0;
		@(posedge clk_i);
		chk1(controller_irq_o, 1'b1);
		chk1(head_load_o, 1'b1);
		meas(1'b0, 1'b1);
		chk1(n >= 14 && n <= 19, 1'b1);
		clear_irq();
		rw_done_i <= 1'b1;
		@(posedge clk_i);
		rw_done_i <= 1'b0;
		meas(1'b1, 1'b0);
		chk1(n >= 62 && n <= 67, 1'b1);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_basic();
		pos(`FSIC_OP_RECAL, 8'h00, 32'h0000_0020, 0, 64);
		pos(`FSIC_OP_SEEK, 8'h03, 32'h0000_0320, 3, 64);
		apb(1'b1, `FSIC_ADDR_CTRL, 32'h0000_0001);
		apb(1'b1, `FSIC_ADDR_CTRL, 32'h0000_0000);
		query(32'h0000_0080);
		pos(`FSIC_OP_SEEK, 8'h02, 32'h0000_0220, 5, 0);
		apb(1'b1, `FSIC_ADDR_SPEC, 32'h0001_0210);
		pos(`FSIC_OP_SEEK, 8'h00, 32'h0000_0020, 3, 128);
		apb(1'b1, `FSIC_ADDR_SPEC, 32'h0000_0210);
		pos(`FSIC_OP_SEEK, 8'h64, 32'h0000_6420, 103, 0);
		pos(`FSIC_OP_RECAL, 8'h00, 32'h0000_0070, 24, 0);
		cmd(`FSIC_OP_SENSE_DRV, 8'h00);
		apb(1'b0, `FSIC_ADDR_RSLT, 32'h0000_0000);
		chk(r & 32'h00ff_0000, 32'h0068_0000);
		chk1(controller_irq_o, 1'b0);
		t_xfer();
		t_head();
		finish_test();
	end
endmodule // floppy_seek_interrupt_control_bench
